// ### hdl/tcs_pkg.sv
package tcs_pkg;
	localparam int TCS_AW = 12;
	// Register byte addresses
	localparam logic [11:0] TCS_A_SELECT = 12'h000;
	localparam logic [11:0] TCS_A_STATUS = 12'h004;
	localparam logic [11:0] TCS_A_MASK = 12'h008;
	localparam logic [11:0] TCS_A_LINE = 12'h00c;
	// Select register fields
	localparam int TCS_B_VIOL = 7;
	localparam int TCS_B_T1 = 6;
	localparam int TCS_B_SYNC = 5;
	localparam int TCS_B_PROT = 4;
	localparam logic [7:0] TCS_SEL_RST = 8'h11;
	localparam logic [7:0] TCS_SEL_WMASK = 8'hf3;
	// Status bits
	localparam int TCS_S_LOSS = 5;
	localparam int TCS_S_REGAIN = 0;
	localparam int TCS_S_VIOL = 1;
	localparam logic [7:0] TCS_STAT_USED = 8'h23;
	// Source codes
	localparam logic [1:0] TCS_SRC_LOOP0 = 2'h0;
	localparam logic [1:0] TCS_SRC_PLL = 2'h1;
	localparam logic [1:0] TCS_SRC_EXT = 2'h2;
	localparam logic [1:0] TCS_SRC_LOOP3 = 2'h3;
	// 8 kHz frame: 12500 cycles of 100 MHz
	localparam int TCS_CLK_MHZ = 100;
	localparam int TCS_FRAME_US = 125;
	localparam int TCS_FRAME_CYC = TCS_FRAME_US * TCS_CLK_MHZ;
	localparam int TCS_FW = 14;

	typedef struct packed {
		logic viol;
		logic t1;
		logic sync;
		logic prot;
		logic [1:0] rsvd;
		logic [1:0] src;
	} tcs_sel_t;

	typedef struct packed {
		logic rec_clk;
		logic pll_clk;
		logic ext_clk;
	} tcs_clks_t;

	typedef enum logic [1:0] {
		TCS_ST_REC = 2'b00,
		TCS_ST_LOST = 2'b01,
		TCS_ST_PLL = 2'b11,
		TCS_ST_EXT = 2'b10
	} tcs_state_t;
endpackage

// ### hdl/tcs_sync3.sv
`timescale 1ns/100ps
module tcs_sync3 (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Asynchronous level in, filtered level out
	input wire logic din,
	output logic dout
);
	logic [2:0] s_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_q <= 3'h0;
		end else begin
			s_q <= {s_q[1:0], din};
		end
	end

	// Change counted once stages two and three agree
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			dout <= 1'b0;
		end else if (s_q[1] == s_q[2]) begin
			dout <= s_q[2];
		end
	end
endmodule

// ### hdl/tcs_top.sv
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
module tcs_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [tcs_pkg::TCS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clock sources and line status
	input wire tcs_pkg::tcs_clks_t clk_in,
	input wire logic recovery_lost,
	input wire logic base_rate,
	// Transmit framer control
	output logic tx_clk_sel_pll,
	output logic tx_clk_sel_ext,
	output logic tx_clk,
	output logic tx_frame_align,
	output logic violation_insert,
	output logic t1_mode,
	// Transmit timing pins, enable low while driving
	output logic tx_serial_clock_oe_n,
	output logic tx_frame_sync_oe_n,
	output logic tx_multiframe_sync_oe_n,
	// Interrupt
	output logic irq
);
	import tcs_pkg::*;

	tcs_sel_t sel_q;
	logic [7:0] stat_q;
	logic [7:0] mask_q;
	tcs_state_t st_q, st_d;
	logic [TCS_FW-1:0] frm_q;
	logic lost_s, rec_s, pll_s, ext_s;
	logic wr, rd, hit;
	logic viol_req, loss_ev, regain_ev, align_pulse, loop_sel;
	tcs_sel_t wsel;

	// Pin inputs except base_rate through three-stage filters
	tcs_sync3 u_lost (.core_clk(core_clk), .arst_n(arst_n),
		.din(recovery_lost), .dout(lost_s));
	tcs_sync3 u_rec (.core_clk(core_clk), .arst_n(arst_n),
		.din(clk_in.rec_clk), .dout(rec_s));
	tcs_sync3 u_pll (.core_clk(core_clk), .arst_n(arst_n),
		.din(clk_in.pll_clk), .dout(pll_s));
	tcs_sync3 u_ext (.core_clk(core_clk), .arst_n(arst_n),
		.din(clk_in.ext_clk), .dout(ext_s));

	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	assign wsel = tcs_sel_t'(pwdata[7:0]);
	assign hit = (paddr == TCS_A_SELECT) || (paddr == TCS_A_STATUS) ||
		(paddr == TCS_A_MASK) || (paddr == TCS_A_LINE);
	assign loop_sel = (sel_q.src == TCS_SRC_LOOP0) ||
		(sel_q.src == TCS_SRC_LOOP3);

	// Rising edge of the insert bit requests one violation
	assign viol_req = wr && (paddr == TCS_A_SELECT) && wsel.viol &&
		!sel_q.viol;

	// Select register; reserved bits are held at zero
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_q <= tcs_sel_t'(TCS_SEL_RST);
		end else if (wr && paddr == TCS_A_SELECT) begin
			sel_q <= tcs_sel_t'(pwdata[7:0] & TCS_SEL_WMASK);
		end
	end

	// Timing source state
	always_comb begin
		st_d = st_q;
		case (st_q)
			TCS_ST_REC: begin
				if (!loop_sel) begin
					st_d = (sel_q.src == TCS_SRC_PLL) ? TCS_ST_PLL : TCS_ST_EXT;
				end else if (lost_s && sel_q.prot) begin
					st_d = TCS_ST_LOST;
				end
			end
			TCS_ST_LOST: begin
				if (!loop_sel) begin
					st_d = (sel_q.src == TCS_SRC_PLL) ? TCS_ST_PLL : TCS_ST_EXT;
				end else if (!lost_s || !sel_q.prot) begin
					st_d = TCS_ST_REC;
				end
			end
			TCS_ST_PLL: begin
				if (loop_sel) begin
					st_d = TCS_ST_REC;
				end else if (sel_q.src == TCS_SRC_EXT) begin
					st_d = TCS_ST_EXT;
				end
			end
			TCS_ST_EXT: begin
				if (loop_sel) begin
					st_d = TCS_ST_REC;
				end else if (sel_q.src == TCS_SRC_PLL) begin
					st_d = TCS_ST_PLL;
				end
			end
			default: st_d = TCS_ST_REC;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= TCS_ST_PLL;
		end else begin
			st_q <= st_d;
		end
	end

	assign loss_ev = (st_q == TCS_ST_REC) && (st_d == TCS_ST_LOST);
	assign regain_ev = (st_q == TCS_ST_LOST) && (st_d == TCS_ST_REC);

	// Clock selection outputs
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_clk_sel_pll <= 1'b1;
			tx_clk_sel_ext <= 1'b0;
			tx_clk <= 1'b0;
		end else begin
			tx_clk_sel_pll <= (st_d == TCS_ST_PLL) || (st_d == TCS_ST_LOST);
			tx_clk_sel_ext <= (st_d == TCS_ST_EXT);
			case (st_d)
				TCS_ST_REC: tx_clk <= rec_s;
				TCS_ST_EXT: tx_clk <= ext_s;
				default: tx_clk <= pll_s;
			endcase
		end
	end

	// Free-running 8 kHz frame counter counting core_clk cycles
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			frm_q <= '0;
		end else if (frm_q == TCS_FW'(TCS_FRAME_CYC - 1)) begin
			frm_q <= '0;
		end else begin
			frm_q <= frm_q + 1'b1;
		end
	end

	assign align_pulse = (frm_q == TCS_FW'(TCS_FRAME_CYC - 1));

	// Frame alignment strobe only with sync on and PLL selected
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_frame_align <= 1'b0;
		end else begin
			tx_frame_align <= align_pulse && sel_q.sync &&
				(st_d == TCS_ST_PLL);
		end
	end

	// One-cycle violation pulse and mode output
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			violation_insert <= 1'b0;
			t1_mode <= 1'b0;
		end else begin
			violation_insert <= viol_req;
			t1_mode <= sel_q.t1;
		end
	end

	// Timing pin directions at base rate
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_serial_clock_oe_n <= 1'b1;
			tx_frame_sync_oe_n <= 1'b1;
			tx_multiframe_sync_oe_n <= 1'b1;
		end else begin
			tx_serial_clock_oe_n <= !(base_rate && loop_sel);
			tx_frame_sync_oe_n <= !(base_rate && loop_sel);
			tx_multiframe_sync_oe_n <= !(base_rate && loop_sel);
		end
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_q <= 8'h00;
		end else begin
			logic [7:0] set_v;
			logic [7:0] clr_v;
			set_v = 8'h00;
			set_v[TCS_S_LOSS] = loss_ev;
			set_v[TCS_S_REGAIN] = regain_ev;
			set_v[TCS_S_VIOL] = viol_req;
			clr_v = (wr && paddr == TCS_A_STATUS) ? pwdata[7:0] : 8'h00;
			stat_q <= ((stat_q & ~clr_v) | set_v) & TCS_STAT_USED;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= 8'h00;
		end else if (wr && paddr == TCS_A_MASK) begin
			mask_q <= pwdata[7:0] & TCS_STAT_USED;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_q & mask_q);
		end
	end

	// APB answer: ready in the access phase, read data from setup
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !hit;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0;
		end else if (rd && !penable) begin
			case (paddr)
				TCS_A_SELECT: prdata <= {24'h0, sel_q};
				TCS_A_STATUS: prdata <= {24'h0, stat_q};
				TCS_A_MASK: prdata <= {24'h0, mask_q};
				TCS_A_LINE: prdata <= {28'h0, base_rate, lost_s,
					st_q};
				default: prdata <= 32'h0;
			endcase
		end
	end
endmodule

// ### sim/tcs_top_props.sv
`timescale 1ns/100ps
module tcs_top_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// Observed ports
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic base_rate,
	input wire logic tx_clk_sel_pll,
	input wire logic tx_clk_sel_ext,
	input wire logic tx_frame_align,
	input wire logic violation_insert,
	input wire logic tx_serial_clock_oe_n,
	input wire logic tx_frame_sync_oe_n,
	input wire logic tx_multiframe_sync_oe_n,
	input wire logic irq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	chk_ready_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_viol_once: assert property (violation_insert |=> !violation_insert)
		else $error("violation pulse too long");
	chk_align_pll: assert property (tx_frame_align |-> tx_clk_sel_pll)
		else $error("alignment without pll source");
	chk_align_gap: assert property (tx_frame_align |=> !tx_frame_align[*8])
		else $error("alignment pulses too close");
	chk_src_excl: assert property (!(tx_clk_sel_pll && tx_clk_sel_ext))
		else $error("two sources selected");
	chk_pins_equal: assert property (tx_serial_clock_oe_n == tx_frame_sync_oe_n
		&& tx_frame_sync_oe_n == tx_multiframe_sync_oe_n)
		else $error("timing pin directions differ");
	chk_pins_rate: assert property (!base_rate[*2] |-> tx_serial_clock_oe_n)
		else $error("pins driven outside base rate");
	chk_pins_ext: assert property (tx_clk_sel_ext[*2] |-> tx_serial_clock_oe_n)
		else $error("pins driven with external source");
	cover property (violation_insert);
	cover property (tx_frame_align);
	cover property (irq);
	cover property (!tx_serial_clock_oe_n);
endmodule
bind tcs_top tcs_top_props u_props (.core_clk, .arst_n, .psel, .penable,
	.pwrite, .prdata, .pready, .pslverr, .base_rate, .tx_clk_sel_pll,
	.tx_clk_sel_ext, .tx_frame_align, .violation_insert,
	.tx_serial_clock_oe_n, .tx_frame_sync_oe_n, .tx_multiframe_sync_oe_n, .irq);

// ### sim/tcs_top_tb_top.sv
`timescale 1ns/100ps
module tcs_top_tb_top;
	import tcs_pkg::*;
	logic core_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic recovery_lost = 0, base_rate = 0, pready, pslverr, err, irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic tx_clk_sel_pll, tx_clk_sel_ext, tx_clk, tx_frame_align;
	logic violation_insert, t1_mode, tx_serial_clock_oe_n;
	logic tx_frame_sync_oe_n, tx_multiframe_sync_oe_n;
	logic [7:0] sv [3] = '{8'h31, 8'h30, 8'h11};
	tcs_clks_t clk_in = '0;
	int mismatches = 0, total_checks = 0, cyc = 0, nv = 0, na = 0, a0;
	tcs_top dut (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .clk_in, .recovery_lost,
		.base_rate, .tx_clk_sel_pll, .tx_clk_sel_ext, .tx_clk,
		.tx_frame_align, .violation_insert, .t1_mode, .tx_serial_clock_oe_n,
		.tx_frame_sync_oe_n, .tx_multiframe_sync_oe_n, .irq);
	always #5 core_clk = ~core_clk;
	task print_verdict;
		if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) begin
		clk_in <= tcs_clks_t'(clk_in + 3'h1);
		cyc <= cyc + 1;
		if (violation_insert === 1'b1) nv <= nv + 1;
		if (tx_frame_align === 1'b1) na <= na + 1;
		if (cyc == 60000) begin
			mismatches = mismatches + 1;
			print_verdict();
		end
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	initial begin
		tick(16);
		arst_n <= 1;
		tick(1);
		rdc(TCS_A_SELECT, 32'h11);
		chk(tx_clk_sel_pll, 1);
		chk(t1_mode, 0);
		rdc(12'h010, 32'h0);
		chk(err, 1);
		wr(TCS_A_SELECT, 32'hdc);
		rdc(TCS_A_SELECT, 32'hd0);
		wr(TCS_A_SELECT, 32'hd0);
		tick(3);
		chk(nv, 1);
		chk(t1_mode, 1);
		base_rate <= 1;
		for (int i = 0; i < 4; i++) begin
			wr(TCS_A_SELECT, 32'h10 | i);
			tick(3);
			chk(tx_serial_clock_oe_n, i == 1 || i == 2);
			chk(tx_clk_sel_ext, i == 2);
		end
		wr(TCS_A_STATUS, 32'h23);
		wr(TCS_A_MASK, 32'h20);
		wr(TCS_A_SELECT, 32'h10);
		recovery_lost <= 1;
		tick(10);
		chk(tx_clk_sel_pll, 1);
		chk(irq, 1);
		recovery_lost <= 0;
		tick(10);
		chk(tx_clk_sel_pll, 0);
		wr(TCS_A_MASK, 32'h0);
		tick(2);
		chk(irq, 0);
		wr(TCS_A_STATUS, 32'h23);
		wr(TCS_A_MASK, 32'h20);
		wr(TCS_A_SELECT, 32'h00);
		recovery_lost <= 1;
		tick(10);
		chk(tx_clk_sel_pll, 0);
		apb(1'b0, TCS_A_STATUS, 32'h0);
		chk(rd[5], 0);
		chk(irq, 0);
		recovery_lost <= 0;
		for (int i = 0; i < 3; i++) begin
			wr(TCS_A_SELECT, {24'h0, sv[i]});
			a0 = na;
			tick(12600);
			chk(na != a0, i == 0);
		end
		print_verdict();
	end
endmodule
